// ===== logic/sfc_pkg.sv
// Function
// - fields other than clock select valid only when smartcard select is 0
// - bit 7 chooses async or clocked sync
// - async: length bit 0 eight, 1 seven
// - seven bits: lsb first, msb dropped
// - clocked sync always uses eight bits
// - format bits ignored in sync mode
// - parity enable adds and checks parity
// - multiprocessor format: no parity at all
// - parity sense 0 even, 1 odd
// - transmit one or two stop bits
// - receiver checks only first stop bit
// - low second stop is next start
// - multiprocessor bit overrides parity bits
// - clock select: divide by 1,4,16,64
// - clock select given as exponent n
package sfc_pkg;
	// -------------------------------------------------
	// register map
	// -------------------------------------------------
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 8;
	localparam logic [3:0]  ADDR_MODE       = 4'h0;
	localparam logic [3:0]  ADDR_SCMODE     = 4'h1;
	localparam logic [3:0]  ADDR_STATUS     = 4'h2;
	localparam logic [7:0]  MODE_RESET      = 8'h00;
	localparam logic [7:0]  SCMODE_RESET    = 8'h00;
	// -------------------------------------------------
	// field positions
	// -------------------------------------------------
	localparam int          BIT_SYNC        = 7;
	localparam int          BIT_CHAR_LEN    = 6;
	localparam int          BIT_PAR_EN      = 5;
	localparam int          BIT_ODD         = 4;
	localparam int          BIT_STOP        = 3;
	localparam int          BIT_MPROC       = 2;
	localparam int          BIT_CKS_HI      = 1;
	localparam int          BIT_CKS_LO      = 0;
	localparam int          BIT_SC_SEL      = 0;
	// -------------------------------------------------
	// prescaler
	// -------------------------------------------------
	localparam int          PRE_W           = 6;
	localparam logic [5:0]  PRE_MAX_0       = 6'h00;
	localparam logic [5:0]  PRE_MAX_1       = 6'h03;
	localparam logic [5:0]  PRE_MAX_2       = 6'h0F;
	localparam logic [5:0]  PRE_MAX_3       = 6'h3F;
	localparam logic [3:0]  LEN_SEVEN       = 4'h7;
	localparam logic [3:0]  LEN_EIGHT       = 4'h8;
endpackage : sfc_pkg

// ===== logic/sfc_prescaler.sv
`timescale 1ns/1ps
module sfc_prescaler
	import sfc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] sel,
	output logic            tick
);
	logic [PRE_W-1:0] cnt_reg;
	logic [PRE_W-1:0] cnt_next;
	logic [PRE_W-1:0] max_v;
	logic             tick_reg;
	logic             tick_next;

	// -------------------------------------------------
	// divider
	// -------------------------------------------------
	always_comb begin
		unique case (sel)
			2'h0: max_v = PRE_MAX_0;
			2'h1: max_v = PRE_MAX_1;
			2'h2: max_v = PRE_MAX_2;
			2'h3: max_v = PRE_MAX_3;
		endcase
		// a shrinking limit must not strand the count above it
		if (cnt_reg >= max_v) begin
			cnt_next  = '0;
			tick_next = 1'b1;
		end else begin
			cnt_next  = cnt_reg + 6'h01;
			tick_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

	// -------------------------------------------------
	// checks
	// -------------------------------------------------
	property p_div4;
		@(posedge clk) disable iff (!rst_n)
		(tick && sel == 2'h1) ##1 (sel == 2'h1) [*4]
			|-> tick && !$past(tick);
	endproperty
	a_div4: assert property (p_div4) else $error("divide by 4 broken");
endmodule : sfc_prescaler

// ===== logic/sfc_mode_cfg.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module sfc_mode_cfg
	import sfc_pkg::*;
(
	input  wire logic              CLK_SYS,
	input  wire logic              RESET_N,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [DATA_W-1:0] RDATA,
	output logic                   SMARTCARD_MODE,
	output logic                   SYNC_MODE,
	output logic      [3:0]        CHAR_BITS,
	output logic                   LSB_FIRST_FORCED,
	output logic                   TX_DROP_MSB,
	output logic                   PARITY_ON,
	output logic                   PARITY_ODD,
	output logic                   TX_TWO_STOP,
	output logic                   RX_CHECK_ONE_STOP,
	output logic                   RX_STOP2_AS_START,
	output logic                   MULTIPROC_ON,
	output logic      [1:0]        CLK_EXP_N,
	output logic                   BAUD_CLK_TICK
);
	// -------------------------------------------------
	// registers
	// -------------------------------------------------
	logic [7:0] serial_mode_config_reg;
	logic [7:0] serial_mode_config_next;
	logic       smartcard_mode_sel_reg;
	logic       smartcard_mode_sel_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic       char_len_sel;
	logic       parity_enable_bit;
	logic       multiproc_enable;
	logic       clk_src_sel_hi;
	logic       clk_src_sel_lo;
	logic       normal_mode;
	logic       async_mode;

	always_comb begin
		serial_mode_config_next = serial_mode_config_reg;
		smartcard_mode_sel_next = smartcard_mode_sel_reg;
		rdata_next              = 8'h00;
		if (WR && ADDR == ADDR_MODE) begin
			serial_mode_config_next = WDATA;
		end
		if (WR && ADDR == ADDR_SCMODE) begin
			smartcard_mode_sel_next = WDATA[BIT_SC_SEL];
		end
		if (RD) begin
			unique case (ADDR)
				ADDR_MODE:   rdata_next = serial_mode_config_reg;
				ADDR_SCMODE: rdata_next = {7'h00, smartcard_mode_sel_reg};
				ADDR_STATUS: rdata_next = {2'h0, CLK_EXP_N, CHAR_BITS};
				default:     rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			serial_mode_config_reg <= MODE_RESET;
			smartcard_mode_sel_reg <= SCMODE_RESET[BIT_SC_SEL];
			rdata_reg              <= 8'h00;
		end else begin
			serial_mode_config_reg <= serial_mode_config_next;
			smartcard_mode_sel_reg <= smartcard_mode_sel_next;
			rdata_reg              <= rdata_next;
		end
	end

	// -------------------------------------------------
	// field decode
	// -------------------------------------------------
	assign char_len_sel      = serial_mode_config_reg[BIT_CHAR_LEN];
	assign parity_enable_bit = serial_mode_config_reg[BIT_PAR_EN];
	assign multiproc_enable  = serial_mode_config_reg[BIT_MPROC];
	assign clk_src_sel_hi    = serial_mode_config_reg[BIT_CKS_HI];
	assign clk_src_sel_lo    = serial_mode_config_reg[BIT_CKS_LO];
	// smartcard meanings of these bits belong to another block
	assign normal_mode       = !smartcard_mode_sel_reg;
	assign async_mode        = normal_mode && !serial_mode_config_reg[BIT_SYNC];

	// -------------------------------------------------
	// decoded settings, registered for clean outputs
	// -------------------------------------------------
	logic [3:0] char_bits_next;
	logic       seven_next;
	logic       par_on_next;
	logic       par_odd_next;
	logic       two_stop_next;
	logic       mproc_next;
	logic       one_stop_next;
	logic       sync_next;
	logic [1:0] exp_next;
	logic [3:0] char_bits_reg;
	logic       seven_reg;
	logic       par_on_reg;
	logic       par_odd_reg;
	logic       two_stop_reg;
	logic       mproc_reg;
	logic       one_stop_reg;
	logic       sync_reg;
	logic [1:0] exp_reg;
	logic       smc_reg;

	always_comb begin
		sync_next      = normal_mode && serial_mode_config_reg[BIT_SYNC];
		seven_next     = async_mode && char_len_sel;
		// sync mode lands here too: length bit is ignored
		char_bits_next = seven_next ? LEN_SEVEN : LEN_EIGHT;
		mproc_next     = async_mode && multiproc_enable;
		par_on_next    = async_mode && parity_enable_bit && !multiproc_enable;
		par_odd_next   = par_on_next && serial_mode_config_reg[BIT_ODD];
		two_stop_next  = async_mode && serial_mode_config_reg[BIT_STOP];
		exp_next       = {clk_src_sel_hi, clk_src_sel_lo};
		// receiver never looks past the first stop bit
		one_stop_next  = 1'b1;
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			char_bits_reg <= LEN_EIGHT;
			seven_reg     <= 1'b0;
			par_on_reg    <= 1'b0;
			par_odd_reg   <= 1'b0;
			two_stop_reg  <= 1'b0;
			mproc_reg     <= 1'b0;
			one_stop_reg  <= 1'b1;
			sync_reg      <= 1'b0;
			exp_reg       <= 2'h0;
			smc_reg       <= 1'b0;
		end else begin
			char_bits_reg <= char_bits_next;
			seven_reg     <= seven_next;
			par_on_reg    <= par_on_next;
			par_odd_reg   <= par_odd_next;
			two_stop_reg  <= two_stop_next;
			mproc_reg     <= mproc_next;
			one_stop_reg  <= one_stop_next;
			sync_reg      <= sync_next;
			exp_reg       <= exp_next;
			smc_reg       <= smartcard_mode_sel_reg;
		end
	end

	sfc_prescaler u_pre (
		.clk   (CLK_SYS),
		.rst_n (RESET_N),
		.sel   (serial_mode_config_reg[BIT_CKS_HI:BIT_CKS_LO]),
		.tick  (BAUD_CLK_TICK)
	);

	// -------------------------------------------------
	// outputs
	// -------------------------------------------------
	assign RDATA             = rdata_reg;
	assign SMARTCARD_MODE    = smc_reg;
	assign SYNC_MODE         = sync_reg;
	assign CHAR_BITS         = char_bits_reg;
	assign LSB_FIRST_FORCED  = seven_reg;
	assign TX_DROP_MSB       = seven_reg;
	assign PARITY_ON         = par_on_reg;
	assign PARITY_ODD        = par_odd_reg;
	assign TX_TWO_STOP       = two_stop_reg;
	// receiver sees only the first stop, in every mode
	assign RX_CHECK_ONE_STOP = one_stop_reg;
	assign RX_STOP2_AS_START = two_stop_reg;
	assign MULTIPROC_ON      = mproc_reg;
	assign CLK_EXP_N         = exp_reg;

	// -------------------------------------------------
	// checks
	// -------------------------------------------------
	property p_write_read;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(WR && ADDR == ADDR_MODE) ##1 (RD && ADDR == ADDR_MODE && !WR)
			|=> RDATA == $past(WDATA, 2);
	endproperty
	a_write_read: assert property (p_write_read) else $error("mode readback wrong");

	property p_sync_len;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		SYNC_MODE |-> CHAR_BITS == LEN_EIGHT && !PARITY_ON && !TX_TWO_STOP && !MULTIPROC_ON;
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("sync mode not plain");

	property p_mproc_parity;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		MULTIPROC_ON |-> !PARITY_ON && !PARITY_ODD;
	endproperty
	a_mproc_parity: assert property (p_mproc_parity) else $error("parity in multiproc");

	property p_smc_off;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		SMARTCARD_MODE |-> !SYNC_MODE && !PARITY_ON && CHAR_BITS == LEN_EIGHT;
	endproperty
	a_smc_off: assert property (p_smc_off) else $error("fields live in smartcard");

	property p_seven;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(WR && ADDR == ADDR_MODE && WDATA[BIT_CHAR_LEN] && !WDATA[BIT_SYNC] && !smartcard_mode_sel_reg)
			##1 !WR |=> CHAR_BITS == LEN_SEVEN && TX_DROP_MSB && LSB_FIRST_FORCED;
	endproperty
	a_seven: assert property (p_seven) else $error("seven bit not applied");

	property p_parity;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		PARITY_ON |-> $past(serial_mode_config_reg[BIT_PAR_EN]) && !SYNC_MODE;
	endproperty
	a_parity: assert property (p_parity) else $error("parity source wrong");

	property p_odd;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		PARITY_ON |-> PARITY_ODD == $past(serial_mode_config_reg[BIT_ODD]);
	endproperty
	a_odd: assert property (p_odd) else $error("parity sense wrong");

	property p_stop;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		TX_TWO_STOP |-> RX_STOP2_AS_START && RX_CHECK_ONE_STOP && !SYNC_MODE
			&& $past(serial_mode_config_reg[BIT_STOP]);
	endproperty
	a_stop: assert property (p_stop) else $error("stop handling wrong");

	property p_exp;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		##1 CLK_EXP_N == $past(serial_mode_config_reg[BIT_CKS_HI:BIT_CKS_LO]);
	endproperty
	a_exp: assert property (p_exp) else $error("clock exponent wrong");

	// -------------------------------------------------
	// field sources, one output at a time
	// -------------------------------------------------
	property p_rdata_idle;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!$past(RD) |-> RDATA == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

	property p_one_stop;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		RX_CHECK_ONE_STOP;
	endproperty
	a_one_stop: assert property (p_one_stop) else $error("second stop checked");

	property p_sync_src;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		SYNC_MODE == ($past(serial_mode_config_reg[BIT_SYNC]) && !SMARTCARD_MODE);
	endproperty
	a_sync_src: assert property (p_sync_src) else $error("sync source wrong");

	property p_char_len;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!SYNC_MODE && !SMARTCARD_MODE
			|-> (CHAR_BITS == LEN_SEVEN) == $past(serial_mode_config_reg[BIT_CHAR_LEN]);
	endproperty
	a_char_len: assert property (p_char_len) else $error("length source wrong");

	property p_char_eight;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		SYNC_MODE || SMARTCARD_MODE |-> CHAR_BITS == LEN_EIGHT;
	endproperty
	a_char_eight: assert property (p_char_eight) else $error("length not eight");

	property p_drop_msb;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		TX_DROP_MSB == (CHAR_BITS == LEN_SEVEN) && LSB_FIRST_FORCED == TX_DROP_MSB;
	endproperty
	a_drop_msb: assert property (p_drop_msb) else $error("seven bit flags wrong");

	property p_par_src;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		PARITY_ON == ($past(serial_mode_config_reg[BIT_PAR_EN])
			&& !$past(serial_mode_config_reg[BIT_MPROC]) && !SYNC_MODE && !SMARTCARD_MODE);
	endproperty
	a_par_src: assert property (p_par_src) else $error("parity enable wrong");

	property p_mproc_src;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		MULTIPROC_ON == ($past(serial_mode_config_reg[BIT_MPROC]) && !SYNC_MODE
			&& !SMARTCARD_MODE);
	endproperty
	a_mproc_src: assert property (p_mproc_src) else $error("multiproc wrong");

	property p_stop_src;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		TX_TWO_STOP == ($past(serial_mode_config_reg[BIT_STOP]) && !SYNC_MODE
			&& !SMARTCARD_MODE);
	endproperty
	a_stop_src: assert property (p_stop_src) else $error("stop source wrong");

	property p_odd_off;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!PARITY_ON |-> !PARITY_ODD;
	endproperty
	a_odd_off: assert property (p_odd_off) else $error("odd without parity");

	// -------------------------------------------------
	// coverage
	// -------------------------------------------------
	c_sync:  cover property (@(posedge CLK_SYS) SYNC_MODE);
	c_seven: cover property (@(posedge CLK_SYS) CHAR_BITS == LEN_SEVEN && PARITY_ODD);
	c_mproc: cover property (@(posedge CLK_SYS) MULTIPROC_ON && TX_TWO_STOP);
	c_div64: cover property (@(posedge CLK_SYS) CLK_EXP_N == 2'h3 && BAUD_CLK_TICK);
endmodule : sfc_mode_cfg

// ===== tb/sfc_peer_model.sv
`timescale 1ns/1ps
module sfc_peer_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       tick,
	output logic      [7:0] gap
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [7:0] gap_reg;
	logic [7:0] gap_next;
	// ----------
	// baud clock spacing seen by the far side
	// ----------
	always_comb begin
		cnt_next = cnt_reg + 8'h01;
		gap_next = gap_reg;
		if (tick) begin
			gap_next = cnt_reg + 8'h01;
			cnt_next = 8'h00;
		end
	end
	// saturating not needed: widest period is 64
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			gap_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
			gap_reg <= gap_next;
		end
	end
	assign gap = gap_reg;
endmodule : sfc_peer_model

// ===== tb/sfc_mode_cfg_tb_top.sv
`timescale 1ns/1ps
module sfc_mode_cfg_tb_top;
	import sfc_pkg::*;
	logic        clk_sys    = 1'b0;
	logic        reset_n    = 1'b0;
	logic [3:0]  addr       = 4'h0;
	logic [7:0]  wdata      = 8'h00;
	logic        wr         = 1'b0;
	logic        rd         = 1'b0;
	logic [7:0]  rdata;
	logic [7:0]  got;
	wire  [15:0] outs;
	wire  [7:0]  gap;
	wire         tick;
	int          num_errors = 0;
	int          cmp_count  = 0;
	logic [7:0]  corner [10] = '{8'h00, 8'h40, 8'hC0, 8'h80, 8'h20, 8'h30, 8'h08, 8'h34,
		8'h7F, 8'hFF};
	// ----------
	// clock and instances
	// ----------
	always #10 clk_sys = ~clk_sys;
	sfc_mode_cfg u_sfc_mode_cfg (
		.CLK_SYS(clk_sys), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .SMARTCARD_MODE(outs[15]),
		.SYNC_MODE(outs[14]), .CHAR_BITS(outs[13:10]), .LSB_FIRST_FORCED(outs[9]),
		.TX_DROP_MSB(outs[8]), .PARITY_ON(outs[7]), .PARITY_ODD(outs[6]),
		.TX_TWO_STOP(outs[5]), .RX_CHECK_ONE_STOP(outs[4]),
		.RX_STOP2_AS_START(outs[3]), .MULTIPROC_ON(outs[2]), .CLK_EXP_N(outs[1:0]),
		.BAUD_CLK_TICK(tick)
	);
	sfc_peer_model u_sfc_peer_model (.clk(clk_sys), .rst_n(reset_n), .tick(tick), .gap(gap));
	// ----------
	// helpers
	// ----------
	function automatic logic [15:0] exp_out(input logic [7:0] m, input logic sc);
		logic a;
		logic pon;
		a   = !sc && !m[7];
		pon = a && m[5] && !m[2];
		return {sc, !sc && m[7], (a && m[6]) ? 4'h7 : 4'h8, a && m[6], a && m[6], pon,
			pon && m[4], a && m[3], 1'b1, a && m[3], a && m[2], m[1:0]};
	endfunction : exp_out
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr    <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask : bus_rd
	task automatic apply(input logic [7:0] m, input logic sc);
		logic [15:0] e;
		e = exp_out(m, sc);
		bus_wr(4'h0, m);
		bus_wr(4'h1, {7'h00, sc});
		@(posedge clk_sys);
		#1;
		chk(outs, e);
		bus_rd(4'h0, got);
		chk({8'h00, got}, {8'h00, m});
		bus_rd(4'h1, got);
		chk({8'h00, got}, {15'h0000, sc});
		bus_rd(4'h2, got);
		chk({8'h00, got}, {10'h000, m[1:0], e[13:10]});
	endtask : apply
	task end_sim;
		$display("compares=%0d errors=%0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// ----------
	// sequence
	// ----------
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		end_sim;
	end
	initial begin
		void'($urandom(32'h1650C1E2));
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk(outs, exp_out(8'h00, 1'b0));
		bus_rd(4'h0, got);
		chk({8'h00, got}, 16'h0000);
		foreach (corner[i]) apply(corner[i], 1'b0);
		apply(8'hFF, 1'b1);
		for (int i = 0; i < 24; i++) apply(8'($urandom), ($urandom % 4) == 0);
		// mid-run reset must bring every field back
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk(outs, exp_out(8'h00, 1'b0));
		bus_rd(4'h0, got);
		chk({8'h00, got}, 16'h0000);
		bus_rd(4'h1, got);
		chk({8'h00, got}, 16'h0000);
		// write then read with no gap between the strobes
		@(posedge clk_sys);
		addr  <= 4'h0;
		wdata <= 8'h5A;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr    <= 1'b0;
		rd    <= 1'b1;
		@(posedge clk_sys);
		rd    <= 1'b0;
		#1;
		chk({8'h00, rdata}, 16'h005A);
		@(posedge clk_sys);
		#1;
		chk({8'h00, rdata}, 16'h0000);
		apply(8'h00, 1'b0);
		// status is read-only, a write must leave it alone
		bus_wr(4'h2, 8'hFF);
		bus_rd(4'h2, got);
		chk({8'h00, got}, 16'h0008);
		bus_rd(4'hF, got);
		chk({8'h00, got}, 16'h0000);
		// two full periods of the slowest divider fit in the wait
		for (int n = 0; n < 4; n++) begin
			bus_wr(4'h0, {6'h00, 2'(n)});
			repeat (140) @(posedge clk_sys);
			#1;
			chk({8'h00, gap}, 16'(1 << (2 * n)));
		end
		end_sim;
	end
endmodule : sfc_mode_cfg_tb_top
